// [verilog/prio_flood_params.svh]
// Register offsets, field positions and reset values of the priority map
// and flood control register group. Definitions only.
`ifndef PRIO_FLOOD_PARAMS_SVH
`define PRIO_FLOOD_PARAMS_SVH
`define OFS_RULE_IRQ_FLAGS 8'h7e
`define OFS_RULE_IRQ_ENABLES 8'h7f
`define OFS_TAG_QUEUE_MAP_LOW 8'h80
`define OFS_TAG_QUEUE_MAP_HIGH 8'h81
`define OFS_TWO_QUEUE_FOLD 8'h82
`define OFS_UNKNOWN_UNICAST_FLOOD 8'h83
`define RST_RULE_IRQ_ENABLES 5'h00
`define RST_TAG_QUEUE_MAP_LOW 8'h50
`define RST_TAG_QUEUE_MAP_HIGH 8'hfa
`define RST_TWO_QUEUE_FOLD_SEL 2'h2
`define RST_FOLD_RESERVED 6'h08
`define RST_FLOOD_RESERVED 2'h2
`define RST_FLOOD_EN 1'h0
`define RST_FLOOD_MAP 5'h00
`define POS_FOLD_SEL 6
`define POS_FLOOD_EN 5
`define POS_FLOOD_RESERVED 6
`endif

// [verilog/prio_flood_pkg.sv]
// Types shared by the priority map and flood control register group.
// Assumes the byte-wide management register port of the switch core.
package prio_flood_pkg;
   typedef logic [1:0] queue_t;
   typedef struct packed {
      logic [1:0] sel;
      logic [5:0] reserved;
   } fold_reg_s;
   typedef struct packed {
      logic [1:0] reserved;
      logic en;
      logic [4:0] map;
   } flood_reg_s;
endpackage : prio_flood_pkg

// [verilog/prio_flood_ctrl.sv]
// Priority map and unknown-unicast flood control register group.
// Assumes a byte-wide management register port, synchronous to CLK, and
// a forwarding datapath that presents tags and samples the results.
`timescale 1ns/1ps
`include "prio_flood_params.svh"

// How it works
// - Read-only per-port rule interrupt flags
// - Writable per-port interrupt enables, reset zero
// - Tag maps onto queues 0 to 3
// - Eight two-bit queue fields across two registers
// - Reset map pairs tags onto queues 0-3
// - Two-queue mode folds queue result low/high
// - Result 0 always low, 3 always high
// - Selector 00, 10, 11 set fold split
// - Unknown unicast forwarded only when enabled
// - Map 00000 discards, 11111 floods all
// - Map bit 0 selects port 1 upward
module prio_flood_ctrl #(
   parameter int PORTS = 5
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic [PORTS-1:0] RULE_IRQ_SRC,
   output logic IRQ,
   input wire logic [2:0] TAG_PRIO,
   input wire logic TWO_QUEUE_MODE,
   output logic [1:0] QUEUE_SEL,
   output logic QUEUE_HIGH,
   output logic [PORTS-1:0] FLOOD_PORTS
);
   // Status, enable and flood map bytes hold exactly five port bits
   if (PORTS != 5) begin : g_ports_check
      $error("prio_flood_ctrl serves exactly five ports");
   end

   // The flood enable sits just above the port map; the selector on top
   if (`POS_FLOOD_EN != PORTS || `POS_FOLD_SEL != 6) begin : g_layout_check
      $error("prio_flood_ctrl field layout does not fit the port count");
   end

   logic [PORTS-1:0] rule_irq_flags;
   logic [PORTS-1:0] rule_irq_enables;
   logic [7:0] tag_queue_map_low;
   logic [7:0] tag_queue_map_high;
   prio_flood_pkg::fold_reg_s two_queue_fold;
   prio_flood_pkg::flood_reg_s unknown_unicast_flood;
   logic [PORTS-1:0] next_rule_irq_enables;
   logic [7:0] next_tag_queue_map_low;
   logic [7:0] next_tag_queue_map_high;
   prio_flood_pkg::fold_reg_s next_two_queue_fold;
   prio_flood_pkg::flood_reg_s next_unknown_unicast_flood;
   logic [7:0] next_rdata;
   prio_flood_pkg::queue_t next_queue;
   logic next_high;
   logic [PORTS-1:0] next_flood;
   logic next_irq;
   logic [PORTS-1:0] irq_pending;
   logic wr_enables;
   logic wr_map_low;
   logic wr_map_high;
   logic wr_fold;
   logic wr_flood;

   // Two-bit field of a packed map byte
   function automatic prio_flood_pkg::queue_t field2(
      input logic [7:0] map,
      input logic [1:0] idx
   );
      field2 = map[{idx, 1'b0} +: 2];
   endfunction : field2

   // Fold a four-queue result onto low (0) or high (1)
   function automatic logic fold(
      input prio_flood_pkg::queue_t q,
      input logic [1:0] sel
   );
      unique case (q)
         2'h0: fold = 1'b0;
         2'h3: fold = 1'b1;
         2'h1: fold = sel[0];
         default: fold = sel[1];
      endcase
   endfunction : fold

   // Write strobe of one register offset
   function automatic logic reg_hit(
      input logic wr,
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      reg_hit = wr && (addr == ofs);
   endfunction : reg_hit

   // Write strobes, one per writable register; the flag byte and unmapped
   // offsets have none, so writes there fall away
   assign wr_enables = reg_hit(REG_WR, REG_ADDR, `OFS_RULE_IRQ_ENABLES);
   assign wr_map_low = reg_hit(REG_WR, REG_ADDR, `OFS_TAG_QUEUE_MAP_LOW);
   assign wr_map_high = reg_hit(REG_WR, REG_ADDR, `OFS_TAG_QUEUE_MAP_HIGH);
   assign wr_fold = reg_hit(REG_WR, REG_ADDR, `OFS_TWO_QUEUE_FOLD);
   assign wr_flood = reg_hit(REG_WR, REG_ADDR, `OFS_UNKNOWN_UNICAST_FLOOD);

   // Rule interrupt enables
   always_comb begin
      next_rule_irq_enables = rule_irq_enables;
      if (wr_enables) begin
         next_rule_irq_enables = REG_WDATA[PORTS-1:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rule_irq_enables <= `RST_RULE_IRQ_ENABLES;
      end else begin
         rule_irq_enables <= next_rule_irq_enables;
      end
   end

   // Queue fields of tags 0 to 3
   always_comb begin
      next_tag_queue_map_low = tag_queue_map_low;
      if (wr_map_low) begin
         next_tag_queue_map_low = REG_WDATA;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tag_queue_map_low <= `RST_TAG_QUEUE_MAP_LOW;
      end else begin
         tag_queue_map_low <= next_tag_queue_map_low;
      end
   end

   // Queue fields of tags 4 to 7
   always_comb begin
      next_tag_queue_map_high = tag_queue_map_high;
      if (wr_map_high) begin
         next_tag_queue_map_high = REG_WDATA;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tag_queue_map_high <= `RST_TAG_QUEUE_MAP_HIGH;
      end else begin
         tag_queue_map_high <= next_tag_queue_map_high;
      end
   end

   // Two-queue selector; reserved bits are read-only so their reset
   // values stay, whatever software writes into them
   always_comb begin
      next_two_queue_fold = two_queue_fold;
      if (wr_fold) begin
         // Code 01 is stored as written; it folds result 1 high, result 2 low
         next_two_queue_fold.sel = REG_WDATA[`POS_FOLD_SEL +: 2];
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         two_queue_fold.sel <= `RST_TWO_QUEUE_FOLD_SEL;
         two_queue_fold.reserved <= `RST_FOLD_RESERVED;
      end else begin
         two_queue_fold <= next_two_queue_fold;
      end
   end

   // Unknown-unicast enable and port map; reserved bits stay put
   always_comb begin
      next_unknown_unicast_flood = unknown_unicast_flood;
      if (wr_flood) begin
         next_unknown_unicast_flood.en = REG_WDATA[`POS_FLOOD_EN];
         next_unknown_unicast_flood.map = REG_WDATA[PORTS-1:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         unknown_unicast_flood.reserved <= `RST_FLOOD_RESERVED;
         unknown_unicast_flood.en <= `RST_FLOOD_EN;
         unknown_unicast_flood.map <= `RST_FLOOD_MAP;
      end else begin
         unknown_unicast_flood <= next_unknown_unicast_flood;
      end
   end

   // Flags follow the rule engine's level; clearing is done at the source
   assign rule_irq_flags = RULE_IRQ_SRC;

   // Read data of the previous cycle's address; unmapped offsets read 0
   always_comb begin
      next_rdata = 8'h00;
      unique case (REG_ADDR)
         `OFS_RULE_IRQ_FLAGS: begin
            next_rdata = {3'h0, rule_irq_flags};
         end
         `OFS_RULE_IRQ_ENABLES: begin
            next_rdata = {3'h0, rule_irq_enables};
         end
         `OFS_TAG_QUEUE_MAP_LOW: begin
            next_rdata = tag_queue_map_low;
         end
         `OFS_TAG_QUEUE_MAP_HIGH: begin
            next_rdata = tag_queue_map_high;
         end
         `OFS_TWO_QUEUE_FOLD: begin
            next_rdata = two_queue_fold;
         end
         `OFS_UNKNOWN_UNICAST_FLOOD: begin
            next_rdata = unknown_unicast_flood;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= next_rdata;
      end
   end

   // Four-queue result of the presented tag
   always_comb begin
      if (TAG_PRIO[2]) begin
         next_queue = field2(tag_queue_map_high, TAG_PRIO[1:0]);
      end else begin
         next_queue = field2(tag_queue_map_low, TAG_PRIO[1:0]);
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         QUEUE_SEL <= 2'h0;
      end else begin
         QUEUE_SEL <= next_queue;
      end
   end

   // Low/high fold; stays low in four-queue operation
   always_comb begin
      next_high = 1'b0;
      if (TWO_QUEUE_MODE) begin
         next_high = fold(next_queue, two_queue_fold.sel);
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         QUEUE_HIGH <= 1'b0;
      end else begin
         QUEUE_HIGH <= next_high;
      end
   end

   // Interrupt request; level, so it drops one cycle after the source clears
   assign irq_pending = rule_irq_flags & rule_irq_enables;

   always_comb begin
      next_irq = |irq_pending;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= next_irq;
      end
   end

   // Bit 0 of the map is port 1; zero map or no enable drops the frame
   always_comb begin
      next_flood = '0;
      if (unknown_unicast_flood.en) begin
         next_flood = unknown_unicast_flood.map;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         FLOOD_PORTS <= '0;
      end else begin
         FLOOD_PORTS <= next_flood;
      end
   end
endmodule : prio_flood_ctrl

// [sim/prio_flood_ctrl_asserts.sv]
// Port-level checker for the priority map and flood control group.
// Bound into every prio_flood_ctrl; shadows only the fields it needs.
`timescale 1ns/1ps
module prio_flood_ctrl_asserts #(
   parameter int PORTS = 5
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic [PORTS-1:0] RULE_IRQ_SRC,
   input wire logic IRQ,
   input wire logic TWO_QUEUE_MODE,
   input wire logic [1:0] QUEUE_SEL,
   input wire logic QUEUE_HIGH,
   input wire logic [PORTS-1:0] FLOOD_PORTS
);
   logic [PORTS-1:0] en, fmap;
   logic [1:0] fs;
   logic fen;
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B) en <= '0;
      else if (REG_WR && REG_ADDR == 8'h7f) en <= REG_WDATA[PORTS-1:0];
   // Selector resets to 10, the split used until software says otherwise
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B) {fs, fen, fmap} <= 8'h80;
      else if (REG_WR && REG_ADDR == 8'h82) fs <= REG_WDATA[7:6];
      else if (REG_WR && REG_ADDR == 8'h83) {fen, fmap} <= REG_WDATA[5:0];
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   irq_level_a:
      assert property (IRQ == |($past(RULE_IRQ_SRC) & $past(en)))
      else $error("IRQ differs from flags and enables");
   flag_read_a:
      assert property ($past(REG_ADDR) == 8'h7e && $past(RULE_IRQ_SRC, 2) ==
         $past(RULE_IRQ_SRC) |-> REG_RDATA == {3'h0, $past(RULE_IRQ_SRC)})
      else $error("Flag read wrong");
   enable_read_a:
      assert property ($past(REG_ADDR) == 8'h7f && !$past(REG_WR) |->
         REG_RDATA == {3'h0, $past(en)}) else $error("Enable read wrong");
   flood_gate_a:
      assert property (FLOOD_PORTS == ($past(fen) ? $past(fmap) : 5'h00))
      else $error("Flood ports wrong");
   four_queue_a:
      assert property (!$past(TWO_QUEUE_MODE) |-> !QUEUE_HIGH)
      else $error("High queue outside two-queue mode");
   fold_ends_a:
      assert property ($past(TWO_QUEUE_MODE) && QUEUE_SEL inside {2'h0, 2'h3}
         |-> QUEUE_HIGH == QUEUE_SEL[1]) else $error("Fold end wrong");
   fold_split_a:
      assert property ($past(TWO_QUEUE_MODE) && $past(fs) == 2'h2 |->
         QUEUE_HIGH == QUEUE_SEL[1]) else $error("Fold split wrong");
   read_unmapped_a: assert property (!($past(REG_ADDR) inside
      {[8'h7e:8'h83]}) |-> REG_RDATA == 8'h00) else $error("Unmapped read");
   cover property (IRQ);
   cover property ($past(TWO_QUEUE_MODE) && QUEUE_HIGH);
   cover property (FLOOD_PORTS == 5'h1f);
endmodule : prio_flood_ctrl_asserts
bind prio_flood_ctrl prio_flood_ctrl_asserts #(.PORTS(PORTS)) u_chk (.*);

// [sim/tb_priority_map_and_flood_ctrl.sv]
// Self-checking bench for the priority map and flood control group.
// Drives all ports directly; the checker binds itself in.
`timescale 1ns/1ps
module tb_priority_map_and_flood_ctrl;
   logic CLK = 1'h0, RST_B = 1'h0, REG_WR = 1'h0, TWO_QUEUE_MODE = 1'h0;
   logic IRQ, QUEUE_HIGH;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
   logic [4:0] RULE_IRQ_SRC = 5'h00, FLOOD_PORTS;
   logic [2:0] TAG_PRIO = 3'h0;
   logic [1:0] QUEUE_SEL;
   int n_errors = 0, n_checks = 0;
   prio_flood_ctrl u_dut (.*);
   initial forever #2 CLK = ~CLK;
   task tick;
      @(posedge CLK);
      #1;
   endtask : tick
   task chk(input string n, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'h1;
      tick;
      REG_WR = 1'h0;
      tick;
   endtask : wr
   task rd(input logic [7:0] a, e);
      REG_ADDR = a;
      tick;
      chk("REG_RDATA", REG_RDATA, e);
   endtask : rd
   task t_irq;
      rd(8'h7f, 8'h00);
      wr(8'h7f, 8'hff);
      rd(8'h7f, 8'h1f);
      wr(8'h7f, 8'h05);
      RULE_IRQ_SRC = 5'h02;
      tick;
      chk("IRQ", IRQ, 1'h0);
      wr(8'h7e, 8'hff);
      rd(8'h7e, 8'h02);
      rd(8'ha0, 8'h00);
      RULE_IRQ_SRC = 5'h14;
      tick;
      chk("IRQ", IRQ, 1'h1);
      wr(8'h7f, 8'h00);
      tick;
      chk("IRQ", IRQ, 1'h0);
      RULE_IRQ_SRC = 5'h00;
   endtask : t_irq
   // Runs on the reset tag map, so tag 2q yields queue q
   task t_fold;
      logic [1:0] s, q;
      logic h;
      TWO_QUEUE_MODE = 1'h1;
      for (int k = 0; k < 12; k++) begin
         q = k[1:0];
         s = k[3:2] == 2'h0 ? 2'h2 : {k[3], k[3]};
         if (q == 2'h0 && k > 3) wr(8'h82, {s, 6'h08});
         TAG_PRIO = {q, 1'h0};
         tick;
         h = q == 2'h3 || q == 2'h2 && s[1] || q == 2'h1 && s[0];
         chk("QUEUE_HIGH", QUEUE_HIGH, h);
      end
      rd(8'h82, 8'hc8);
      TWO_QUEUE_MODE = 1'h0;
      tick;
      chk("QUEUE_HIGH", QUEUE_HIGH, 1'h0);
   endtask : t_fold
   task t_map;
      logic [7:0] m;
      logic [1:0] e;
      for (int t = 0; t < 16; t++) begin
         if (t == 8) wr(8'h80, 8'he4);
         if (t == 8) wr(8'h81, 8'h1b);
         m = t[2] ? 8'h1b : 8'he4;
         TAG_PRIO = t[2:0];
         tick;
         e = t < 8 ? t[2:1] : m[2*t[1:0] +: 2];
         chk("QUEUE_SEL", QUEUE_SEL, e);
      end
      rd(8'h80, 8'he4);
      rd(8'h81, 8'h1b);
   endtask : t_map
   task t_flood;
      logic [4:0] m [4] = '{5'h00, 5'h07, 5'h0f, 5'h1f};
      rd(8'h83, 8'h80);
      wr(8'h83, 8'h9f);
      tick;
      chk("FLOOD_PORTS", FLOOD_PORTS, 8'h00);
      foreach (m[i]) begin
         wr(8'h83, {3'h5, m[i]});
         tick;
         chk("FLOOD_PORTS", FLOOD_PORTS, m[i]);
      end
      rd(8'h83, 8'hbf);
   endtask : t_flood
   task test_done;
      $display("Checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (12) @(posedge CLK);
      #1 RST_B = 1'h1;
      t_irq;
      t_fold;
      t_map;
      t_flood;
      test_done;
   end
endmodule : tb_priority_map_and_flood_ctrl
